// File: hdl/adc_mode_lvds_output_ctrl.sv
// converter mode, dither, lvds output setup and clock upset alarm with avalon-mm registers
`timescale 1ns/1ns
`default_nettype none
module adc_mode_lvds_output_ctrl (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [conv_ctrl_pkg::ADDR_W-1:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [3:0] i_byteenable,
    input wire logic [conv_ctrl_pkg::DATA_W-1:0] i_writedata,
    output logic [conv_ctrl_pkg::DATA_W-1:0] o_readdata,
    output logic o_waitrequest,
    input wire logic i_clk_tree_a,
    input wire logic i_clk_tree_b,
    input wire logic i_global_powerdown_pin,
    input wire logic i_cal_done,
    output logic o_cal_status_pin,
    output logic o_lvds_enable,
    output logic o_interleave,
    output logic o_conv_a_input,
    output logic o_conv_b_input,
    output logic o_trim_input,
    output logic o_dither_enable,
    output logic o_dither_boost,
    output logic o_dither_error_tradeoff,
    output logic o_swing_low,
    output logic o_hiz_term,
    output logic o_demux,
    output logic o_aligned,
    output logic [conv_ctrl_pkg::BUS_N-1:0] o_bus_oe,
    output logic [conv_ctrl_pkg::BUS_N-1:0] o_strobe_oe,
    output logic [conv_ctrl_pkg::BUS_N-1:0] o_dclk_oe,
    output logic o_lsb_strobe,
    output logic o_chan_a_powerdown,
    output logic o_chan_b_powerdown,
    output logic o_global_powerdown
);
    import conv_ctrl_pkg::*;

    // ------------------------------------------------------------
    // state of the whole block
    // ------------------------------------------------------------
    typedef struct packed {
        bus_st_t st;
        logic waitreq;
        logic [DATA_W-1:0] rdata;
        logic [CTRL_W-1:0] ctrl;
        logic [OM_W-1:0] outmode;
        logic [PWR_W-1:0] power;
        logic clock_upset_flag;
        logic ta_s1;
        logic ta_s2;
        logic tb_s1;
        logic tb_s2;
        logic pd_s1;
        logic pd_s2;
        logic pd_prev;
        logic cal_s1;
        logic cal_s2;
        logic gpd_prev;
        logic cal_pin;
        logic lvds_en;
        logic interleave;
        logic conv_a_in;
        logic conv_b_in;
        logic trim_in;
        logic dith_en;
        logic dith_boost;
        logic dith_err;
        logic swing_low;
        logic hiz;
        logic demux;
        logic aligned;
        logic [BUS_N-1:0] bus_oe;
        logic [BUS_N-1:0] stb_oe;
        logic [BUS_N-1:0] dclk_oe;
        logic lsb_strobe;
        logic gpd_out;
    } state_t;

    state_t s_ff;
    state_t nxt_s;
    logic mismatch;
    logic pd_exit;
    logic clr_hit;
    logic accept_wr;
    logic [DATA_W-1:0] rd_mux;

    // byte-lane merge of a write into a register image
    function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old_v,
                                                     input logic [DATA_W-1:0] new_v,
                                                     input logic [3:0] be);
        logic [DATA_W-1:0] mask;
        mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old_v & ~mask) | (new_v & mask);
    endfunction : lane_merge

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [DATA_W-1:0] merged;
        logic [BUS_N-1:0] buses;
        logic lsb;
        logic [DATA_W-1:0] be_mask;
        merged = '0;
        buses = '0;
        lsb = 1'b0;
        be_mask = '0;
        nxt_s = s_ff;
        // two-stage synchronisers for pins and the clock tree samples
        nxt_s.ta_s1 = i_clk_tree_a;
        nxt_s.ta_s2 = s_ff.ta_s1;
        nxt_s.tb_s1 = i_clk_tree_b;
        nxt_s.tb_s2 = s_ff.tb_s1;
        nxt_s.pd_s1 = i_global_powerdown_pin;
        nxt_s.pd_s2 = s_ff.pd_s1;
        nxt_s.pd_prev = s_ff.pd_s2;
        nxt_s.cal_s1 = i_cal_done;
        nxt_s.cal_s2 = s_ff.cal_s1;
        nxt_s.gpd_prev = s_ff.ctrl[CB_GLOBAL_PD];

        // read image, sampled when the request is first seen
        rd_mux = '0;
        case (i_address)
            OFS_CTRL: rd_mux[CTRL_W-1:0] = s_ff.ctrl;
            OFS_OUTMODE: rd_mux[OM_W-1:0] = s_ff.outmode;
            OFS_POWER: rd_mux[PWR_W-1:0] = s_ff.power;
            OFS_STATUS: begin
                rd_mux[SB_FLAG] = s_ff.clock_upset_flag;
                rd_mux[SB_CAL_PIN] = s_ff.cal_pin;
                rd_mux[SB_PAIRS +: 6] = s_ff.demux ? PAIRS_DEMUX2 : PAIRS_DEMUX1;
                rd_mux[SB_DCLKS +: 3] = s_ff.demux ? LINES_DEMUX2 : LINES_DEMUX1;
                rd_mux[SB_STROBES +: 3] = s_ff.lsb_strobe ? LINES_NONE
                                        : (s_ff.demux ? LINES_DEMUX2 : LINES_DEMUX1);
                rd_mux[SB_BITS +: 4] = s_ff.lsb_strobe ? BITS_LSB_STROBE : BITS_FULL;
            end
            default: rd_mux = '0;
        endcase

        // one-cycle answer: waitrequest drops the cycle after a request arrives
        accept_wr = 1'b0;
        case (s_ff.st)
            BUS_IDLE: begin
                if (i_read || i_write) begin
                    nxt_s.st = BUS_ANSWER;
                    nxt_s.waitreq = 1'b0;
                    nxt_s.rdata = rd_mux;
                end
            end
            BUS_ANSWER: begin
                nxt_s.st = BUS_IDLE;
                nxt_s.waitreq = 1'b1;
                accept_wr = i_write;
            end
            default: begin
                nxt_s.st = BUS_IDLE;
                nxt_s.waitreq = 1'b1;
            end
        endcase

        // register writes at the edge that sees waitrequest low
        merged = lane_merge('0, i_writedata, i_byteenable);
        be_mask = lane_merge('0, '1, i_byteenable); // lanes that a write may change
        if (accept_wr) begin
            case (i_address)
                OFS_CTRL: nxt_s.ctrl = (s_ff.ctrl & ~be_mask[CTRL_W-1:0]) | merged[CTRL_W-1:0];
                OFS_OUTMODE: begin
                    if (!s_ff.ctrl[CB_LVDS_EN]) begin
                        nxt_s.outmode = (s_ff.outmode & ~be_mask[OM_W-1:0]) | merged[OM_W-1:0];
                    end
                end
                OFS_POWER: nxt_s.power = (s_ff.power & ~be_mask[PWR_W-1:0]) | merged[PWR_W-1:0];
                default: nxt_s.power = s_ff.power;
            endcase
        end

        // clock upset alarm: set wins over the write-one clear
        mismatch = s_ff.ta_s2 ^ s_ff.tb_s2;
        pd_exit = (s_ff.pd_prev & ~s_ff.pd_s2) | (s_ff.gpd_prev & ~s_ff.ctrl[CB_GLOBAL_PD]);
        clr_hit = accept_wr && (i_address == OFS_STATUS) && merged[SB_FLAG];
        nxt_s.clock_upset_flag = (s_ff.clock_upset_flag & ~clr_hit) | mismatch | pd_exit;

        // derived outputs are computed from the next register images, so they change at the same edge
        nxt_s.cal_pin = nxt_s.outmode[OB_CAL_SEL] ? nxt_s.clock_upset_flag : s_ff.cal_s2;
        nxt_s.lvds_en = nxt_s.ctrl[CB_LVDS_EN];
        nxt_s.interleave = nxt_s.ctrl[CB_INTERLEAVE];
        // dual mode routes each input to its own converter, optionally swapped
        nxt_s.conv_a_in = nxt_s.interleave ? nxt_s.ctrl[CB_IL_INPUT] : nxt_s.ctrl[CB_INPUT_SWAP];
        nxt_s.conv_b_in = nxt_s.interleave ? nxt_s.ctrl[CB_IL_INPUT] : ~nxt_s.ctrl[CB_INPUT_SWAP];
        nxt_s.trim_in = nxt_s.interleave & nxt_s.ctrl[CB_IL_INPUT];
        nxt_s.dith_en = nxt_s.ctrl[CB_DITHER_EN];
        nxt_s.dith_boost = nxt_s.ctrl[CB_DITHER_BOOST];
        nxt_s.dith_err = nxt_s.ctrl[CB_DITHER_ERR];
        nxt_s.gpd_out = nxt_s.ctrl[CB_GLOBAL_PD];
        nxt_s.swing_low = (nxt_s.outmode[OB_SWING +: 2] == SWING_LOW);
        nxt_s.hiz = (nxt_s.outmode[OB_SWING +: 2] == SWING_HIZ);
        nxt_s.demux = nxt_s.outmode[OB_DEMUX];
        // staggered unless aligned is chosen; ignored for dual demux-by-1
        nxt_s.aligned = nxt_s.lvds_en & nxt_s.outmode[OB_ALIGN]
                        & (nxt_s.interleave | nxt_s.demux);
        lsb = (nxt_s.outmode[OB_SYNC_PATTERN_SELECT +: 2] == SYNC_LSB_STROBE);
        nxt_s.lsb_strobe = lsb;
        buses = nxt_s.lvds_en ? (nxt_s.demux ? BUSES_DEMUX2 : BUSES_DEMUX1) : '0;
        nxt_s.bus_oe = buses;
        // per-bus enables only trim lines in demux-by-2
        nxt_s.stb_oe = buses & (nxt_s.demux ? nxt_s.outmode[OB_STB_EN +: BUS_N] : BUSES_DEMUX2)
                       & ~{BUS_N{lsb}};
        nxt_s.dclk_oe = buses & (nxt_s.demux ? nxt_s.outmode[OB_DCLK_EN +: BUS_N] : BUSES_DEMUX2);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_ff <= '0;
            s_ff.waitreq <= 1'b1;
            s_ff.ctrl <= CTRL_RST;
            s_ff.outmode <= OUTMODE_RST;
            s_ff.power <= POWER_RST;
            s_ff.dith_en <= CTRL_RST[CB_DITHER_EN];
            s_ff.conv_b_in <= ~CTRL_RST[CB_INPUT_SWAP]; // dual mode routing holds from reset on
        end else begin
            s_ff <= nxt_s;
        end
    end

    // outputs straight from the state register
    assign o_readdata = s_ff.rdata;
    assign o_waitrequest = s_ff.waitreq;
    assign o_cal_status_pin = s_ff.cal_pin;
    assign o_lvds_enable = s_ff.lvds_en;
    assign o_interleave = s_ff.interleave;
    assign o_conv_a_input = s_ff.conv_a_in;
    assign o_conv_b_input = s_ff.conv_b_in;
    assign o_trim_input = s_ff.trim_in;
    assign o_dither_enable = s_ff.dith_en;
    assign o_dither_boost = s_ff.dith_boost;
    assign o_dither_error_tradeoff = s_ff.dith_err;
    assign o_swing_low = s_ff.swing_low;
    assign o_hiz_term = s_ff.hiz;
    assign o_demux = s_ff.demux;
    assign o_aligned = s_ff.aligned;
    assign o_bus_oe = s_ff.bus_oe;
    assign o_strobe_oe = s_ff.stb_oe;
    assign o_dclk_oe = s_ff.dclk_oe;
    assign o_lsb_strobe = s_ff.lsb_strobe;
    assign o_chan_a_powerdown = s_ff.power[PB_CHAN_A];
    assign o_chan_b_powerdown = s_ff.power[PB_CHAN_B];
    assign o_global_powerdown = s_ff.gpd_out;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    chk_upset_sets: assert property (mismatch |=> s_ff.clock_upset_flag)
        else $error("tree mismatch did not set upset flag");
    chk_upset_sticky: assert property (s_ff.clock_upset_flag && !clr_hit |=> s_ff.clock_upset_flag)
        else $error("upset flag dropped without clear");
    chk_upset_clear: assert property (clr_hit && !mismatch && !pd_exit |=> !s_ff.clock_upset_flag)
        else $error("write one did not clear upset flag");
    chk_pd_exit_sets: assert property ($fell(s_ff.pd_s2) |=> s_ff.clock_upset_flag)
        else $error("power-down exit did not set upset flag");
    chk_cal_alarm: assert property (s_ff.outmode[OB_CAL_SEL] && s_ff.clock_upset_flag |-> o_cal_status_pin)
        else $error("cal pin missed alarm");
    chk_dual_route: assert property (!o_interleave |-> o_conv_a_input != o_conv_b_input)
        else $error("dual mode inputs not distinct");
    chk_swap_route: assert property (!o_interleave |-> o_conv_a_input == s_ff.ctrl[CB_INPUT_SWAP])
        else $error("input swap not applied");
    chk_il_route: assert property (o_interleave |-> o_conv_a_input == o_trim_input && o_conv_b_input == o_trim_input)
        else $error("interleave input or trim mismatch");
    chk_swing_dec: assert property (s_ff.outmode[OB_SWING +: 2] == SWING_HIZ |-> o_hiz_term && !o_swing_low)
        else $error("swing decode wrong");
    chk_line_count: assert property (o_lvds_enable && !o_demux |-> o_bus_oe == BUSES_DEMUX1 && o_dclk_oe == BUSES_DEMUX1)
        else $error("demux-by-1 line set wrong");
    chk_align_dual: assert property (!o_interleave && !o_demux |-> !o_aligned)
        else $error("alignment applied in dual demux-by-1");
    chk_lsb_nostrobe: assert property (o_lsb_strobe |-> o_strobe_oe == '0)
        else $error("strobe on during lsb replacement");
    chk_mode_lock: assert property (s_ff.ctrl[CB_LVDS_EN] |=> $stable(s_ff.outmode))
        else $error("output mode changed while lvds enabled");
    chk_bus_answer: assert property (s_ff.st == BUS_IDLE && (i_read || i_write) |=> !o_waitrequest ##1 o_waitrequest)
        else $error("bus answer timing wrong");

    cov_upset: cover property (mismatch ##1 clr_hit);
    cov_demux2_reduced: cover property (o_demux && o_lvds_enable && o_strobe_oe != BUSES_DEMUX2);
    cov_interleave_b: cover property (o_interleave && o_trim_input);
    cov_lsb_mode: cover property (o_lsb_strobe && o_lvds_enable);
endmodule : adc_mode_lvds_output_ctrl
`default_nettype wire

// File: hdl/conv_ctrl_pkg.sv
// constants shared by the converter mode and lvds output control block
package conv_ctrl_pkg;
    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int BUS_N = 4;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_OUTMODE = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_POWER = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hc;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTRL_W = 8;
    localparam int CB_LVDS_EN = 0;
    localparam int CB_INTERLEAVE = 1;
    localparam int CB_INPUT_SWAP = 2;
    localparam int CB_IL_INPUT = 3;
    localparam int CB_DITHER_EN = 4;
    localparam int CB_DITHER_BOOST = 5;
    localparam int CB_DITHER_ERR = 6;
    localparam int CB_GLOBAL_PD = 7;
    localparam logic [CTRL_W-1:0] CTRL_RST = 8'h10;

    // ------------------------------------------------------------
    // output mode register fields
    // ------------------------------------------------------------
    localparam int OM_W = 15;
    localparam int OB_SWING = 0;
    localparam int OB_DEMUX = 2;
    localparam int OB_ALIGN = 3;
    localparam int OB_STB_EN = 4;
    localparam int OB_DCLK_EN = 8;
    localparam int OB_SYNC_PATTERN_SELECT = 12;
    localparam int OB_CAL_SEL = 14;
    localparam logic [OM_W-1:0] OUTMODE_RST = 15'h0ff0;
    localparam logic [1:0] SWING_LOW = 2'h1;
    localparam logic [1:0] SWING_HIZ = 2'h3;
    localparam logic [1:0] SYNC_LSB_STROBE = 2'h2;

    // ------------------------------------------------------------
    // power register and status register fields
    // ------------------------------------------------------------
    localparam int PWR_W = 2;
    localparam int PB_CHAN_A = 0;
    localparam int PB_CHAN_B = 1;
    localparam logic [PWR_W-1:0] POWER_RST = 2'h0;
    localparam int SB_FLAG = 0;
    localparam int SB_CAL_PIN = 1;
    localparam int SB_PAIRS = 8;
    localparam int SB_DCLKS = 16;
    localparam int SB_STROBES = 20;
    localparam int SB_BITS = 24;

    // ------------------------------------------------------------
    // output bus figures
    // ------------------------------------------------------------
    localparam logic [5:0] PAIRS_DEMUX1 = 6'h18;
    localparam logic [5:0] PAIRS_DEMUX2 = 6'h30;
    localparam logic [2:0] LINES_DEMUX1 = 3'h2;
    localparam logic [2:0] LINES_DEMUX2 = 3'h4;
    localparam logic [2:0] LINES_NONE = 3'h0;
    localparam logic [3:0] BITS_FULL = 4'hc;
    localparam logic [3:0] BITS_LSB_STROBE = 4'hb;
    localparam logic [BUS_N-1:0] BUSES_DEMUX1 = 4'h3;
    localparam logic [BUS_N-1:0] BUSES_DEMUX2 = 4'hf;

    // ------------------------------------------------------------
    // register bus answer states
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ANSWER = 1'b1
    } bus_st_t;
endpackage : conv_ctrl_pkg

// File: testbench/adc_mode_lvds_output_ctrl_tb_top.sv
// self-checking bench for the converter mode and lvds output control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module adc_mode_lvds_output_ctrl_tb_top;
    import conv_ctrl_pkg::*;
    logic i_clk = 1'b0, i_rst_n = 1'b0, i_read = 1'b0, i_write = 1'b0;
    logic [ADDR_W-1:0] i_address = '0;
    logic [3:0] i_byteenable = 4'h0;
    logic [DATA_W-1:0] i_writedata = '0, o_readdata, q;
    logic i_clk_tree_a, i_clk_tree_b, i_global_powerdown_pin = 1'b0, i_cal_done = 1'b0;
    logic o_waitrequest, o_cal_status_pin, o_lvds_enable, o_interleave, o_conv_a_input, o_conv_b_input;
    logic o_trim_input, o_dither_enable, o_dither_boost, o_dither_error_tradeoff, o_swing_low, o_hiz_term;
    logic o_demux, o_aligned, o_lsb_strobe, o_chan_a_powerdown, o_chan_b_powerdown, o_global_powerdown;
    logic [BUS_N-1:0] o_bus_oe, o_strobe_oe, o_dclk_oe;
    logic link_clk = 1'b0, glitch = 1'b0;
    logic [2:0] strobes, dclks;
    int n_fail = 0, n_tests = 0, cycles = 0;
    adc_mode_lvds_output_ctrl uut (.i_clk, .i_rst_n, .i_address, .i_read, .i_write, .i_byteenable,
        .i_writedata, .o_readdata, .o_waitrequest, .i_clk_tree_a, .i_clk_tree_b, .i_global_powerdown_pin,
        .i_cal_done, .o_cal_status_pin, .o_lvds_enable, .o_interleave, .o_conv_a_input, .o_conv_b_input,
        .o_trim_input, .o_dither_enable, .o_dither_boost, .o_dither_error_tradeoff, .o_swing_low,
        .o_hiz_term, .o_demux, .o_aligned, .o_bus_oe, .o_strobe_oe, .o_dclk_oe, .o_lsb_strobe,
        .o_chan_a_powerdown, .o_chan_b_powerdown, .o_global_powerdown);
    lvds_rx_model rx (.i_link_clk(link_clk), .i_glitch(glitch), .i_strobe_oe(o_strobe_oe),
        .i_dclk_oe(o_dclk_oe), .o_tree_a(i_clk_tree_a), .o_tree_b(i_clk_tree_b), .o_strobes(strobes),
        .o_dclks(dclks));
    // ------------------------------------------------------------
    // clocks, timeout and closing report
    // ------------------------------------------------------------
    always #2 i_clk = ~i_clk;
    // link clock 125 ns, updated late in the step so both trees are sampled alike
    always begin
        #62 link_clk <= 1'b1;
        #63 link_clk <= 1'b0;
    end
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        i_address <= a;
        i_writedata <= d;
        i_byteenable <= 4'hf;
        i_write <= wr;
        i_read <= !wr;
        do begin
            @(posedge i_clk);
        end while (o_waitrequest !== 1'b0);
        q = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
        @(posedge i_clk);
    endtask : bus
    task automatic settle();
        repeat (3) @(posedge i_clk);
    endtask : settle
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        bus(0, OFS_CTRL, 0); `CHK(q[CTRL_W-1:0], CTRL_RST)
        bus(0, OFS_OUTMODE, 0); `CHK(q[OM_W-1:0], OUTMODE_RST)
        bus(0, OFS_POWER, 0); `CHK(q[PWR_W-1:0], POWER_RST)
        bus(0, OFS_STATUS, 0); `CHK(q[SB_FLAG], 1'b0)
        bus(1, 4'h2, 32'hff); bus(0, 4'h2, 0); `CHK(q, 32'h0)
        bus(0, OFS_CTRL, 0); `CHK(q[CTRL_W-1:0], CTRL_RST)
        bus(1, OFS_POWER, 32'h3); `CHK({o_chan_b_powerdown, o_chan_a_powerdown}, 2'h3)
        bus(1, OFS_POWER, 0); `CHK({o_chan_b_powerdown, o_chan_a_powerdown}, 2'h0)
    endtask : t_reset
    task automatic t_modes();
        logic [7:0] ctl[4] = '{8'h00, 8'h74, 8'h2a, 8'h56};
        logic [6:0] ex[4] = '{7'h20, 7'h47, 7'h7a, 7'h0d};
        for (int i = 0; i < 4; i++) begin
            bus(1, OFS_CTRL, {24'h0, ctl[i]});
            settle();
            `CHK({o_conv_a_input, o_conv_b_input, o_trim_input, o_interleave, o_dither_enable, o_dither_boost,
                o_dither_error_tradeoff}, ex[i])
        end
    endtask : t_modes
    task automatic t_outputs();
        bus(1, OFS_CTRL, 0); bus(1, OFS_OUTMODE, 32'h0355); bus(1, OFS_CTRL, 1); settle();
        `CHK({o_bus_oe, o_strobe_oe, o_dclk_oe}, 12'hf53)
        `CHK({o_swing_low, o_hiz_term, o_demux, o_aligned, strobes, dclks}, 10'h292)
        bus(0, OFS_STATUS, 0); `CHK({q[13:8], q[27:24]}, {PAIRS_DEMUX2, BITS_FULL})
        bus(1, OFS_OUTMODE, 0); bus(0, OFS_OUTMODE, 0); `CHK(q[OM_W-1:0], 15'h0355)
        bus(1, OFS_CTRL, 0); bus(1, OFS_OUTMODE, 32'h0008); bus(1, OFS_CTRL, 1); settle();
        `CHK({o_bus_oe, o_strobe_oe, o_dclk_oe, o_demux, o_aligned, o_swing_low, o_hiz_term}, 16'h3330)
        bus(0, OFS_STATUS, 0); `CHK({q[13:8], q[22:20]}, {PAIRS_DEMUX1, LINES_DEMUX1})
        bus(1, OFS_CTRL, 0); bus(1, OFS_OUTMODE, 32'h2fff); bus(1, OFS_CTRL, 1); settle();
        `CHK({o_strobe_oe, o_dclk_oe, o_lsb_strobe, o_aligned, o_hiz_term}, 11'h07f)
        bus(0, OFS_STATUS, 0); `CHK({q[22:20], q[27:24]}, {LINES_NONE, BITS_LSB_STROBE})
    endtask : t_outputs
    task automatic t_upset();
        i_cal_done <= 1'b1;
        bus(1, OFS_CTRL, 0); settle();
        `CHK(o_cal_status_pin, 1'b1)
        bus(1, OFS_OUTMODE, 32'h4ff0); bus(1, OFS_POWER, 0);
        bus(0, OFS_POWER, 0); `CHK(q[PWR_W-1:0], 2'h0)
        bus(1, OFS_CTRL, 1); bus(1, OFS_STATUS, 1); settle();
        bus(0, OFS_STATUS, 0); `CHK({q[SB_FLAG], o_cal_status_pin}, 2'h0)
        glitch <= 1'b1;
        repeat (20) @(posedge i_clk);
        glitch <= 1'b0;
        repeat (300) @(posedge i_clk);
        bus(0, OFS_STATUS, 0); `CHK({q[SB_FLAG], o_cal_status_pin}, 2'h3)
        bus(1, OFS_STATUS, 0); bus(0, OFS_STATUS, 0); `CHK(q[SB_FLAG], 1'b1)
        bus(1, OFS_STATUS, 1); bus(0, OFS_STATUS, 0); `CHK(q[SB_FLAG], 1'b0)
        bus(1, OFS_CTRL, 32'h81); `CHK({o_global_powerdown, o_lvds_enable}, 2'h3)
        bus(1, OFS_CTRL, 1); settle();
        bus(0, OFS_STATUS, 0); `CHK(q[SB_FLAG], 1'b1)
        bus(1, OFS_STATUS, 1);
        i_global_powerdown_pin <= 1'b1;
        repeat (10) @(posedge i_clk);
        i_global_powerdown_pin <= 1'b0;
        repeat (10) @(posedge i_clk);
        bus(0, OFS_STATUS, 0); `CHK(q[SB_FLAG], 1'b1)
        bus(1, OFS_STATUS, 1); bus(0, OFS_STATUS, 0); `CHK(q[SB_FLAG], 1'b0)
    endtask : t_upset
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        t_reset();
        t_modes();
        t_outputs();
        t_upset();
        test_done();
    end
endmodule : adc_mode_lvds_output_ctrl_tb_top
`default_nettype wire

// File: testbench/lvds_rx_model.sv
// receiver side model: feeds both clock trees and counts the strobe and data clock lines it sees
`timescale 1ns/1ns
`default_nettype none
module lvds_rx_model (
    input wire logic i_link_clk,
    input wire logic i_glitch,
    input wire logic [3:0] i_strobe_oe,
    input wire logic [3:0] i_dclk_oe,
    output logic o_tree_a,
    output logic o_tree_b,
    output logic [2:0] o_strobes,
    output logic [2:0] o_dclks
);
    // ------------------------------------------------------------
    // clock trees and line counts
    // ------------------------------------------------------------
    // tree b follows tree a unless an upset is commanded
    assign o_tree_a = i_link_clk;
    assign o_tree_b = i_link_clk ^ i_glitch;
    // lines that actually toggle toward the receiver
    assign o_strobes = 3'($countones(i_strobe_oe));
    assign o_dclks = 3'($countones(i_dclk_oe));
endmodule : lvds_rx_model
`default_nettype wire
